//--- sbc_pkg.sv
// Shared constants, register map and types for the serial register bank
`default_nettype none
package sbc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SPI_HALF_NS = 100;
  localparam int SPI_HALF_CYC = (SPI_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_NS = 200;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int RW_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [4:0] ADDR_DONE = 5'h07;
  localparam logic [4:0] FRAME_FULL = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  localparam int N_CTRL = 19;
  localparam logic [6:0] CTRL_ADDR [N_CTRL] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0c,
    7'h0d, 7'h10, 7'h14, 7'h15, 7'h17, 7'h18, 7'h19, 7'h1c, 7'h1e};
  localparam logic [7:0] CTRL_WMASK [N_CTRL] = '{
    8'hff, 8'hfb, 8'hf7, 8'h03, 8'h20, 8'hc4, 8'ha7, 8'h3f, 8'h3f, 8'h77,
    8'h77, 8'h70, 8'h77, 8'h77, 8'hff, 8'hff, 8'hff, 8'h05, 8'hff};
  localparam logic [7:0] CTRL_RWH [N_CTRL] = '{
    8'hfc, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_POR [N_CTRL] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_RESTART [N_CTRL] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTRL_KEEP [N_CTRL] = '{
    8'h23, 8'hd9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0] MODE_ADDR = 7'h01;
  localparam int MODE_LSB = 6;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Status registers
  localparam int N_STAT = 9;
  localparam logic [6:0] STAT_ADDR [N_STAT] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam logic [7:0] STAT_MASK [N_STAT] = '{
    8'h5f, 8'hff, 8'h07, 8'hcf, 8'h07, 8'h37, 8'h30, 8'h0f, 8'h0f};
  localparam logic [6:0] LEVEL_ADDR = 7'h48;
  localparam logic [7:0] LEVEL_MASK = 8'hf7;
  localparam logic [6:0] IDENT_ADDR = 7'h7e;

  ////////////////////////////////////////////////////////////////////////////////
  // Types and helpers
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_SHIFT = 3'b010,
    HOST_GAP = 3'b100
  } sbc_host_state_type;

  function automatic logic [7:0] sbc_write_mask(input logic [6:0] a);
    logic [7:0] m;
    m = 8'hff;
    for (int i = 0; i < N_CTRL; i++) begin
      if (CTRL_ADDR[i] == a) begin
        m = CTRL_WMASK[i];
      end
    end
    return m;
  endfunction

endpackage
`default_nettype wire

//--- sbc_link_if.sv
// Serial link between controller and register bank
`timescale 1ns/1ps
`default_nettype none
interface sbc_link_if;
  logic sclk;
  logic csn_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport host (
    output sclk,
    output csn_n,
    output mosi,
    input miso,
    input miso_oe
  );

  modport dev (
    input sclk,
    input csn_n,
    input mosi,
    output miso,
    output miso_oe
  );
endinterface
`default_nettype wire

//--- sbc_status_reg.sv
// One sticky status register, set by hardware and cleared by the link
`timescale 1ns/1ps
`default_nettype none
module sbc_status_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] set,
  input wire logic clr,
  output logic [7:0] flags
);

  // Set wins over a clear in the same cycle; reserved bits never set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= 8'h00;
    end else begin
      flags <= (clr ? 8'h00 : flags) | (set & MASK);
    end
  end

endmodule
`default_nettype wire

//--- sbc_dev_end.sv
// Register bank end: frame decoder, control and status registers
`timescale 1ns/1ps
`default_nettype none
module sbc_dev_end
  import sbc_pkg::*;
#(
  parameter logic [7:0] IDENT = 8'h5a // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic hw_mod_valid,
  input wire logic [6:0] hw_mod_addr,
  input wire logic [7:0] hw_mod_data,
  input wire logic [N_STAT*8-1:0] status_set,
  input wire logic [7:0] wake_levels,
  output logic [N_CTRL*8-1:0] ctrl_flat,
  output logic [N_STAT*8-1:0] status_flat,
  output logic soft_reset_pulse,
  output logic write_pulse,
  sbc_link_if.dev link
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link edge detection
  logic sclk_q;
  logic csn_q;
  logic rise;
  logic fall;
  logic cs_start;
  logic cs_end;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
    end else begin
      sclk_q <= link.sclk;
      csn_q <= link.csn_n;
    end
  end

  assign rise = link.sclk && !sclk_q && !link.csn_n;
  assign fall = !link.sclk && sclk_q && !link.csn_n;
  assign cs_start = !link.csn_n && csn_q;
  assign cs_end = link.csn_n && !csn_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame shifter
  logic [FRAME_BITS-1:0] rx;
  logic [4:0] cnt;
  logic [7:0] tx;
  logic [7:0] rd_value;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx <= '0;
      cnt <= 5'h00;
    end else if (cs_start) begin
      rx <= '0;
      cnt <= 5'h00;
    end else if (rise && cnt != FRAME_FULL) begin
      rx[cnt[3:0]] <= link.mosi;
      cnt <= cnt + 5'h01;
    end
  end

  // Snapshot taken once the address is known, before any write lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx <= 8'h00;
    end else if (rise && cnt == ADDR_DONE) begin
      tx <= rd_value;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.miso <= 1'b0;
    end else if (cs_start) begin
      link.miso <= 1'b0;
    end else if (fall && cnt[3] && !cnt[4]) begin
      link.miso <= tx[cnt[2:0]];
    end else if (fall) begin
      link.miso <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.miso_oe <= 1'b0;
    end else begin
      link.miso_oe <= !link.csn_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame commit
  logic commit;
  logic wr_commit;
  logic [6:0] f_addr;
  logic [7:0] f_data;
  logic soft_reset;

  assign commit = cs_end && cnt == FRAME_FULL;
  assign f_addr = rx[ADDR_BITS-1:0];
  assign f_data = rx[DATA_LSB +: 8];
  assign wr_commit = commit && rx[RW_BIT];
  assign soft_reset = wr_commit && f_addr == MODE_ADDR &&
    f_data[MODE_LSB +: 2] == MODE_SOFT_RESET;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_reset_pulse <= 1'b0;
      write_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_reset;
      write_pulse <= wr_commit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] ctrl [N_CTRL];

  generate
    for (genvar g = 0; g < N_CTRL; g++) begin : g_ctrl
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctrl[g] <= CTRL_POR[g];
        end else if (soft_reset) begin
          ctrl[g] <= CTRL_POR[g];
        end else if (restart) begin
          ctrl[g] <= (ctrl[g] & CTRL_KEEP[g]) | (CTRL_RESTART[g] & ~CTRL_KEEP[g]);
        end else begin
          if (hw_mod_valid && hw_mod_addr == CTRL_ADDR[g]) begin
            ctrl[g] <= (ctrl[g] & ~CTRL_RWH[g]) | (hw_mod_data & CTRL_RWH[g]);
          end else if (wr_commit && f_addr == CTRL_ADDR[g]) begin
            ctrl[g] <= f_data & CTRL_WMASK[g];
          end
        end
      end
      assign ctrl_flat[g*8 +: 8] = ctrl[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Status registers
  logic [7:0] stat [N_STAT];

  generate
    for (genvar s = 0; s < N_STAT; s++) begin : g_stat
      sbc_status_reg #(
        .MASK(STAT_MASK[s])
      ) u_stat (
        .clk(clk),
        .nrst(nrst),
        .set(status_set[s*8 +: 8]),
        .clr(soft_reset || (wr_commit && f_addr == STAT_ADDR[s])),
        .flags(stat[s])
      );
      assign status_flat[s*8 +: 8] = stat[s];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_value = 8'h00;
    for (int i = 0; i < N_CTRL; i++) begin
      if (rx[ADDR_BITS-1:0] == CTRL_ADDR[i]) begin
        rd_value = ctrl[i];
      end
    end
    for (int i = 0; i < N_STAT; i++) begin
      if (rx[ADDR_BITS-1:0] == STAT_ADDR[i]) begin
        rd_value = stat[i];
      end
    end
    if (rx[ADDR_BITS-1:0] == LEVEL_ADDR) begin
      rd_value = wake_levels & LEVEL_MASK;
    end
    if (rx[ADDR_BITS-1:0] == IDENT_ADDR) begin
      rd_value = IDENT;
    end
  end

endmodule
`default_nettype wire

//--- sbc_host_end.sv
// Controller end: issues one frame per request and returns the answer byte
`timescale 1ns/1ps
`default_nettype none
module sbc_host_end
  import sbc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  sbc_link_if.host link
);

  localparam logic [7:0] HALF_LAST = 8'(SPI_HALF_CYC - 1);
  localparam logic [7:0] GAP_LAST = 8'(GAP_CYC - 1);

  sbc_host_state_type state;
  logic [7:0] div;
  logic [3:0] bitn;
  logic [FRAME_BITS-1:0] tx;
  logic [FRAME_BITS-1:0] rx;
  logic [FRAME_BITS-1:0] frame;

  // Reserved bits of control registers are forced to zero on writes
  assign frame = {req_write ? (req_wdata & sbc_write_mask(req_addr)) : 8'h00,
    req_write, req_addr};

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= HOST_IDLE;
      div <= 8'h00;
      bitn <= 4'h0;
      tx <= '0;
      rx <= '0;
      link.sclk <= 1'b0;
      link.csn_n <= 1'b1;
      link.mosi <= 1'b0;
      req_ready <= 1'b1;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (state)
        HOST_IDLE: begin
          if (req_valid) begin
            state <= HOST_SHIFT;
            tx <= frame;
            link.mosi <= frame[0];
            link.csn_n <= 1'b0;
            div <= 8'h00;
            bitn <= 4'h0;
            req_ready <= 1'b0;
          end
        end
        HOST_SHIFT: begin
          if (div == HALF_LAST) begin
            div <= 8'h00;
            link.sclk <= !link.sclk;
            if (!link.sclk) begin
              rx[bitn] <= link.miso;
            end else if (bitn == LAST_BIT[3:0]) begin
              link.csn_n <= 1'b1;
              state <= HOST_GAP;
            end else begin
              bitn <= bitn + 4'h1;
              link.mosi <= tx[bitn + 4'h1];
            end
          end else begin
            div <= div + 8'h01;
          end
        end
        HOST_GAP: begin
          if (div == GAP_LAST) begin
            div <= 8'h00;
            state <= HOST_IDLE;
            req_ready <= 1'b1;
            done <= 1'b1;
            rdata <= rx[DATA_LSB +: 8];
          end else begin
            div <= div + 8'h01;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- sbc_link_chk.sv
// Checker for the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module sbc_link_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Rising serial clock edges within the current frame
  logic sclk_q;
  logic [4:0] edges;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edges <= 5'h00;
    end else if (csn_n) begin
      edges <= 5'h00;
    end else if (sclk && !sclk_q) begin
      edges <= edges + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_frame_len;
    $rose(csn_n) |-> edges == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame without 16 clocks");

  property p_idle_low;
    csn_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock off idle");

  property p_high_len;
    $rose(sclk) |=> sclk [*8];
  endproperty
  a_high_len: assert property (p_high_len) else $error("serial high too short");

  property p_low_len;
    $fell(sclk) |=> (!sclk) [*8];
  endproperty
  a_low_len: assert property (p_low_len) else $error("serial low too short");

  property p_gap;
    $rose(csn_n) |=> csn_n [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("frame gap too short");

  property p_mosi_hold;
    $rose(sclk) |=> $stable(mosi) [*8];
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("host data moved");

  property p_miso_hold;
    $rose(sclk) |=> $stable(miso) [*6];
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("device data moved");

  property p_addr_zero;
    $rose(sclk) && edges < 5'h08 |-> !miso;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("data out in address");

  property p_oe_on;
    $fell(csn_n) |=> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output enable late");

  property p_oe_off;
    $rose(csn_n) |=> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enable stuck");

  c_frame: cover property ($rose(csn_n));
  c_miso_one: cover property ($rose(sclk) && miso);
  c_write: cover property ($rose(sclk) && edges == 5'h07 && mosi);
endmodule
`default_nettype wire

//--- sbc_spi_register_map_test.sv
// Testbench joining both ends of the serial register bank
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_register_map_test;
  import sbc_pkg::*;
  localparam logic [7:0] IDENT_T = 8'h3c; // Arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready;
  logic done;
  logic [7:0] rdata;
  logic restart = 1'b0;
  logic hw_mod_valid = 1'b0;
  logic [6:0] hw_mod_addr = 7'h00;
  logic [7:0] hw_mod_data = 8'h00;
  logic [N_STAT*8-1:0] status_set = '0;
  logic [7:0] wake_levels = 8'hff;
  logic [N_CTRL*8-1:0] ctrl_flat;
  logic [N_STAT*8-1:0] status_flat;
  logic soft_reset_pulse;
  logic write_pulse;
  int n_wr = 0;
  int n_soft = 0;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  sbc_link_if link();
  sbc_host_end i_sbc_host_end (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .done(done), .rdata(rdata), .link(link));
  sbc_dev_end #(.IDENT(IDENT_T)) i_sbc_dev_end (.clk(clk), .nrst(nrst), .restart(restart),
    .hw_mod_valid(hw_mod_valid), .hw_mod_addr(hw_mod_addr), .hw_mod_data(hw_mod_data),
    .status_set(status_set), .wake_levels(wake_levels), .ctrl_flat(ctrl_flat),
    .status_flat(status_flat), .soft_reset_pulse(soft_reset_pulse),
    .write_pulse(write_pulse), .link(link));
  sbc_link_chk i_chk (.clk(clk), .nrst(nrst), .sclk(link.sclk), .csn_n(link.csn_n),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (done !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t transfer timed out", $time);
      wrap_up;
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic hw(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    hw_mod_valid <= 1'b1;
    hw_mod_addr <= a;
    hw_mod_data <= d;
    @(posedge clk);
    hw_mod_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd(7'h01, 8'h00);
    rd(7'h1e, 8'h00);
    rd(7'h7e, IDENT_T);
    rd(7'h7f, 8'h00);
  endtask

  task automatic t_rw;
    xfer(1'b1, 7'h17, 8'ha5);
    xfer(1'b1, 7'h17, 8'h3c);
    chk(rdata, 8'ha5);
    rd(7'h17, 8'h3c);
    rd(7'h17, 8'h3c);
    chk(ctrl_flat[119:112], 8'h3c);
    rd(7'h18, 8'h00);
  endtask

  task automatic t_reserved;
    xfer(1'b1, 7'h04, 8'hff);
    rd(7'h04, 8'h03);
    xfer(1'b1, 7'h48, 8'h00);
    rd(7'h48, 8'hf7);
    xfer(1'b1, 7'h7e, 8'h00);
    rd(7'h7e, IDENT_T);
  endtask

  task automatic t_hwmod;
    hw(7'h02, 8'hff);
    rd(7'h02, 8'h20);
    hw(7'h17, 8'h00);
    rd(7'h17, 8'h3c);
    xfer(1'b1, 7'h02, 8'h00);
    rd(7'h02, 8'h00);
  endtask

  task automatic t_restart;
    xfer(1'b1, 7'h01, 8'h3f);
    xfer(1'b1, 7'h02, 8'hfb);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    rd(7'h01, 8'h23);
    rd(7'h02, 8'hd9);
    rd(7'h17, 8'h00);
  endtask

  // Power-on reset in mid-run brings back the reset values
  task automatic t_por;
    xfer(1'b1, 7'h18, 8'h77);
    rd(7'h18, 8'h77);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(7'h18, 8'h00);
    rd(7'h7e, IDENT_T);
  endtask

  task automatic t_status;
    int w0;
    w0 = n_wr;
    @(posedge clk);
    status_set[7:0] <= 8'hff;
    status_set[71:64] <= 8'hff;
    @(posedge clk);
    status_set <= '0;
    rd(7'h40, 8'h5f);
    chk(status_flat[71:64], 8'h0f);
    rd(7'h40, 8'h5f);
    rd(7'h55, 8'h0f);
    xfer(1'b1, 7'h40, 8'h00);
    rd(7'h40, 8'h00);
    xfer(1'b1, 7'h17, 8'h11);
    xfer(1'b1, 7'h01, 8'hc0);
    rd(7'h17, 8'h00);
    rd(7'h01, 8'h00);
    rd(7'h55, 8'h00);
    chk(8'(n_wr - w0), 8'h03);
    chk(8'(n_soft), 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence and time limit
  always @(negedge clk) begin
    if (write_pulse === 1'b1) begin
      n_wr++;
    end
    if (soft_reset_pulse === 1'b1) begin
      n_soft++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_rw;
    t_reserved;
    t_hwmod;
    t_restart;
    t_por;
    t_status;
    wrap_up;
  end
endmodule
`default_nettype wire
